// ### src/ckg_bus_edges.sv
// Edge, start and stop detection on the synchronised bus lines.
// Assumes scl and sda already passed a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none

module ckg_bus_edges (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic bus_start,
  output logic bus_stop,
  output logic sda_now
);

  ckg_pkg::ckg_edge_s s_reg;
  ckg_pkg::ckg_edge_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.scl_q = scl;
    s_next.sda_q = sda;
    s_next.rise = scl & ~s_reg.scl_q;
    s_next.fall = ~scl & s_reg.scl_q;
    s_next.start = scl & s_reg.scl_q & ~sda & s_reg.sda_q;
    s_next.stop = scl & s_reg.scl_q & sda & ~s_reg.sda_q;
  end

  // Idle bus is high on both lines
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '{scl_q: 1'b1, sda_q: 1'b1, default: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign scl_rise = s_reg.rise;
  assign scl_fall = s_reg.fall;
  assign bus_start = s_reg.start;
  assign bus_stop = s_reg.stop;
  assign sda_now = s_reg.sda_q;

endmodule // ckg_bus_edges

`default_nettype wire

// ### src/ckg_clock_regs.sv
// Control register bank, bytes 0 to 3, of a clock generator,
// reached over the two-wire management bus as a target.
// Assumes the bus host keeps standard bus timing; no stretching.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_regs.svh"

// Notes on behaviour
// R1 - Write enable set: frequency bits accept writes
// R2 - Write enable clear: frequency bits show straps
// R3 - Frequency bits placed 6,5,4,1; start from straps
// R4 - Byte 0 bit 2 reads memory mode strap
// R5 - Byte 0 bit 0 reads processor mode strap
// R6 - Byte 1 bit 7 down/center spread, reset 0
// R7 - Byte 1 bit 6 spread enable, reset 1
// R8 - Byte 1 bits 5:4 spread bandwidth, reset 11
// R9 - Output enable bits, zero forces output low
// R10 - Byte 1 bit 2 processor clock enable
// R11 - Byte 1 bit 1 chooses power-down stop state
// R12 - Byte 1 bit 0 reads multiplier strap
// R13 - Byte 2 bit 7 raises drive strength
// R14 - Byte 3 bit 7 selects 24 or 48 MHz
// R15 - Byte 3 bits 4:3 shift graphics skew
// R16 - Command top bit set: single byte, offset
// R17 - Command zero: block access from byte 0
// R18 - Frequency writes ignored while write disabled
module ckg_clock_regs #(
  parameter logic [6:0] TARGET_ADDR = `CKG_TARGET_ADDR
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic smb_clk,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  input wire logic [3:0] freq_sel_strap,
  input wire logic memory_mode_strap,
  input wire logic cpu_mode_strap,
  input wire logic current_multiplier_strap,
  input wire logic power_down_n,
  output logic freq_sel_bit0,
  output logic freq_sel_bit1,
  output logic freq_sel_bit2,
  output logic freq_sel_bit3,
  output logic spread_center,
  output logic spread_enable,
  output logic spread_bw_bit1,
  output logic spread_bw_bit0,
  output logic aux_cpu_clock_en,
  output logic cpu_clock_en,
  output logic cpu_stop_hiz,
  output logic cpu_stop_drive,
  output logic pci_drive_boost,
  output logic [6:0] pci_clock_en,
  output logic selectable_periph_48m,
  output logic usb_clock_en,
  output logic selectable_periph_en,
  output logic graphics_skew_bit1,
  output logic graphics_skew_bit0,
  output logic [2:0] graphics_clock_en
);

  localparam int NSYNC = 10;

  ckg_pkg::ckg_top_s s_reg;
  ckg_pkg::ckg_top_s s_next;

  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_now;
  logic load;
  logic [7:0] txb;

  assign raw = {smb_clk, smb_data_in, freq_sel_strap, memory_mode_strap,
                cpu_mode_strap, current_multiplier_strap, power_down_n};

  // Bus lines and power-down idle high; no false edge after reset
  ckg_sync #(.W(NSYNC), .INIT(10'h301)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d(raw),
    .q(syn)
  );

  ckg_bus_edges u_edges (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl(syn[9]),
    .sda(syn[8]),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .bus_start(bus_start),
    .bus_stop(bus_stop),
    .sda_now(sda_now)
  );

  // Register byte seen by a read; unmapped or bad command reads zero
  function automatic logic [7:0] rd_byte(ckg_pkg::ckg_top_s s);
    logic [7:0] b;
    b = 8'h00;
    if (s.cmd_ok) begin
      unique case (s.ptr)
        `CKG_OFS_FREQ: b = s.r0;
        `CKG_OFS_CPU: b = s.r1;
        `CKG_OFS_PCI: b = s.r2;
        `CKG_OFS_GFX: b = s.r3;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  function automatic logic [7:0] merge(
    logic [7:0] old,
    logic [7:0] wd,
    logic [7:0] mask
  );
    return (old & ~mask) | (wd & mask);
  endfunction

  always_comb begin
    s_next = s_reg;
    load = 1'b0;
    txb = 8'h00;
    // Strap readbacks track the synchronised pins
    s_next.r0[`CKG_B0_MEM] = syn[3]; // R4
    s_next.r0[`CKG_B0_CPU] = syn[2]; // R5
    s_next.r1[`CKG_B1_MULT] = syn[1]; // R12
    s_next.r0[7] = 1'b0;
    if (!s_reg.r0[`CKG_B0_FS_WE]) begin
      s_next.r0[`CKG_B0_FS2] = syn[4 + 2]; // R2 R3
      s_next.r0[`CKG_B0_FS1] = syn[4 + 1]; // R2 R3
      s_next.r0[`CKG_B0_FS0] = syn[4 + 0]; // R2 R3
      s_next.r0[`CKG_B0_FS3] = syn[4 + 3]; // R2 R3
    end
    // Power-down stop state, first processor mode only
    s_next.hiz = (syn[2] == `CKG_CPU_MODE_FIRST) & ~syn[0]
                 & s_reg.r1[`CKG_B1_PD_HIZ]; // R11
    s_next.stop_drv = (syn[2] == `CKG_CPU_MODE_FIRST) & ~syn[0]
                      & ~s_reg.r1[`CKG_B1_PD_HIZ]; // R11
    if (bus_start) begin
      s_next.st = ckg_pkg::CKG_ADDR;
      s_next.cnt = 4'h0;
      s_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      s_next.st = ckg_pkg::CKG_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.got_cmd = 1'b0;
    end else begin
      unique case (s_reg.st)
        ckg_pkg::CKG_IDLE: begin
        end
        ckg_pkg::CKG_ADDR, ckg_pkg::CKG_RX: begin
          if (scl_rise) begin
            s_next.sh = {s_reg.sh[6:0], sda_now};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == 4'h8) begin
            s_next.cnt = 4'h0;
            s_next.st = ckg_pkg::CKG_ACK;
            s_next.sda_oe = 1'b1;
            if (s_reg.st == ckg_pkg::CKG_ADDR) begin
              s_next.rd = s_reg.sh[0];
              s_next.cnt_sent = 1'b0;
              if (!s_reg.sh[0]) begin
                s_next.got_cmd = 1'b0;
              end
              if (s_reg.sh[7:1] != TARGET_ADDR) begin
                s_next.st = ckg_pkg::CKG_IDLE;
                s_next.sda_oe = 1'b0;
              end
            end else if (!s_reg.got_cmd) begin
              s_next.got_cmd = 1'b1;
              s_next.got_cnt = 1'b0;
              s_next.blk = s_reg.sh == `CKG_CMD_BLOCK; // R17
              s_next.cmd_ok = s_reg.sh[`CKG_CMD_BYTE_BIT]
                              | (s_reg.sh == `CKG_CMD_BLOCK); // R16
              s_next.ptr = s_reg.sh[`CKG_CMD_BYTE_BIT] ?
                           s_reg.sh[6:0] : `CKG_OFS_FREQ; // R16 R17
            end else if (s_reg.blk && !s_reg.got_cnt) begin
              s_next.got_cnt = 1'b1;
              s_next.remain = s_reg.sh; // R17
            end else if (s_reg.cmd_ok
                         && (!s_reg.blk || s_reg.remain != 8'h00)) begin
              unique case (s_reg.ptr)
                `CKG_OFS_FREQ: begin
                  s_next.r0 = merge(s_next.r0, s_reg.sh,
                    s_reg.r0[`CKG_B0_FS_WE] ?
                    (`CKG_B0_MASK_FS | `CKG_B0_MASK_WE)
                    : `CKG_B0_MASK_WE); // R1 R18
                end
                `CKG_OFS_CPU: begin
                  s_next.r1 = merge(s_next.r1, s_reg.sh,
                                    `CKG_B1_MASK);
                end
                `CKG_OFS_PCI: s_next.r2 = s_reg.sh;
                `CKG_OFS_GFX: s_next.r3 = s_reg.sh;
                default: begin
                end
              endcase
              if (s_reg.blk) begin
                s_next.ptr = s_reg.ptr + 7'h01; // R17
                s_next.remain = s_reg.remain - 8'h01;
              end
            end
          end
        end
        ckg_pkg::CKG_ACK: begin
          if (scl_fall) begin
            s_next.sda_oe = 1'b0;
            if (s_reg.rd) begin
              load = 1'b1;
            end else begin
              s_next.st = ckg_pkg::CKG_RX;
            end
          end
        end
        ckg_pkg::CKG_TX: begin
          if (scl_rise) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.cnt == 4'h8) begin
              s_next.sda_oe = 1'b0;
              s_next.cnt = 4'h0;
              s_next.st = ckg_pkg::CKG_MACK;
            end else begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.sh[6];
            end
          end
        end
        ckg_pkg::CKG_MACK: begin
          if (scl_rise) begin
            s_next.nack = sda_now;
          end else if (scl_fall) begin
            if (s_reg.nack) begin
              s_next.st = ckg_pkg::CKG_IDLE;
            end else begin
              load = 1'b1;
            end
          end
        end
        default: begin
          s_next.st = ckg_pkg::CKG_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end
    // Next byte to send; block reads lead with the byte count
    if (load) begin
      if (s_reg.blk && !s_reg.cnt_sent) begin
        txb = `CKG_BLOCK_COUNT; // R17
        s_next.cnt_sent = 1'b1;
      end else begin
        txb = rd_byte(s_reg); // R16
        if (s_reg.blk) begin
          s_next.ptr = s_reg.ptr + 7'h01; // R17
        end
      end
      s_next.sh = txb;
      s_next.sda_oe = ~txb[7];
      s_next.cnt = 4'h0;
      s_next.st = ckg_pkg::CKG_TX;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '{st: ckg_pkg::CKG_IDLE, r1: `CKG_B1_RST, // R6 R7 R8 R10
                 r2: `CKG_B2_RST, r3: `CKG_B3_RST, // R9 R13 R14 R15
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign smb_data_out = 1'b0;
  assign smb_data_oe = s_reg.sda_oe;
  assign freq_sel_bit0 = s_reg.r0[`CKG_B0_FS0]; // R3
  assign freq_sel_bit1 = s_reg.r0[`CKG_B0_FS1]; // R3
  assign freq_sel_bit2 = s_reg.r0[`CKG_B0_FS2]; // R3
  assign freq_sel_bit3 = s_reg.r0[`CKG_B0_FS3]; // R3
  assign spread_center = s_reg.r1[`CKG_B1_MODE]; // R6
  assign spread_enable = s_reg.r1[`CKG_B1_SPREAD]; // R7
  assign spread_bw_bit1 = s_reg.r1[`CKG_B1_BW1]; // R8
  assign spread_bw_bit0 = s_reg.r1[`CKG_B1_BW0]; // R8
  assign aux_cpu_clock_en = s_reg.r1[`CKG_B1_AUX_EN]; // R9
  assign cpu_clock_en = s_reg.r1[`CKG_B1_CPU_EN]; // R10
  assign cpu_stop_hiz = s_reg.hiz;
  assign cpu_stop_drive = s_reg.stop_drv;
  assign pci_drive_boost = s_reg.r2[`CKG_B2_DRV]; // R13
  assign pci_clock_en = s_reg.r2[6:0]; // R9
  assign selectable_periph_48m = s_reg.r3[`CKG_B3_SEL48]; // R14
  assign usb_clock_en = s_reg.r3[`CKG_B3_USB_EN]; // R9
  assign selectable_periph_en = s_reg.r3[`CKG_B3_PER_EN]; // R9
  assign graphics_skew_bit1 = s_reg.r3[`CKG_B3_SKEW1]; // R15
  assign graphics_skew_bit0 = s_reg.r3[`CKG_B3_SKEW0]; // R15
  assign graphics_clock_en = s_reg.r3[2:0]; // R9

endmodule // ckg_clock_regs

`default_nettype wire

// ### src/ckg_pkg.sv
// Types for the clock generator control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ckg_pkg;

  typedef enum logic [2:0] {
    CKG_IDLE = 3'b000,
    CKG_ADDR = 3'b001,
    CKG_RX = 3'b010,
    CKG_ACK = 3'b011,
    CKG_TX = 3'b100,
    CKG_MACK = 3'b101
  } ckg_state_e;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } ckg_edge_s;

  typedef struct packed {
    ckg_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic got_cmd;
    logic blk;
    logic cmd_ok;
    logic got_cnt;
    logic cnt_sent;
    logic nack;
    logic [6:0] ptr;
    logic [7:0] remain;
    logic sda_oe;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] r3;
    logic hiz;
    logic stop_drv;
  } ckg_top_s;

endpackage

// ### src/ckg_regs.svh
// Constants for the clock generator control register bank.
// Assumes inclusion by bare name from files under src/.
`ifndef CKG_REGS_SVH
`define CKG_REGS_SVH

// Register byte offsets
`define CKG_OFS_FREQ 7'h00
`define CKG_OFS_CPU 7'h01
`define CKG_OFS_PCI 7'h02
`define CKG_OFS_GFX 7'h03

// Command codes and block answer
`define CKG_CMD_BYTE_BIT 7
`define CKG_CMD_BLOCK 8'h00
`define CKG_BLOCK_COUNT 8'h04

// Default bus target address (plain default, not documented)
`define CKG_TARGET_ADDR 7'h69

// Byte 0 fields
`define CKG_B0_FS2 6
`define CKG_B0_FS1 5
`define CKG_B0_FS0 4
`define CKG_B0_FS_WE 3
`define CKG_B0_MEM 2
`define CKG_B0_FS3 1
`define CKG_B0_CPU 0
`define CKG_B0_MASK_FS 8'h72
`define CKG_B0_MASK_WE 8'h08

// Byte 1 fields
`define CKG_B1_MODE 7
`define CKG_B1_SPREAD 6
`define CKG_B1_BW1 5
`define CKG_B1_BW0 4
`define CKG_B1_AUX_EN 3
`define CKG_B1_CPU_EN 2
`define CKG_B1_PD_HIZ 1
`define CKG_B1_MULT 0
`define CKG_B1_MASK 8'hFE

// Byte 2 and byte 3 fields
`define CKG_B2_DRV 7
`define CKG_B3_SEL48 7
`define CKG_B3_USB_EN 6
`define CKG_B3_PER_EN 5
`define CKG_B3_SKEW1 4
`define CKG_B3_SKEW0 3

// Reset values
`define CKG_B1_RST 8'h7E
`define CKG_B2_RST 8'h7F
`define CKG_B3_RST 8'h67

// Strap level that selects the first processor mode
`define CKG_CPU_MODE_FIRST 1'b1

`endif

// ### src/ckg_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs are slow levels from pins; no word coherence.
`timescale 1ns/1ps
`default_nettype none

module ckg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [2*W-1:0] s_reg;
  logic [2*W-1:0] s_next;

  always_comb begin
    s_next = {s_reg[W-1:0], d};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      // Reset level per bit follows the idle level of its pin
      s_reg <= {INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg[2*W-1:W];

endmodule // ckg_sync

`default_nettype wire

// ### verification/ckg_clock_regs_assertions.sv
// Checker for the clock generator control register bank.
// Assumes binding to ckg_clock_regs; sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module ckg_clock_regs_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic smb_clk,
  input wire logic smb_data_oe,
  input wire logic cpu_mode_strap,
  input wire logic power_down_n,
  input wire logic spread_center,
  input wire logic spread_enable,
  input wire logic spread_bw_bit1,
  input wire logic spread_bw_bit0,
  input wire logic aux_cpu_clock_en,
  input wire logic cpu_clock_en,
  input wire logic cpu_stop_hiz,
  input wire logic cpu_stop_drive,
  input wire logic pci_drive_boost,
  input wire logic [6:0] pci_clock_en,
  input wire logic selectable_periph_48m,
  input wire logic usb_clock_en,
  input wire logic selectable_periph_en,
  input wire logic graphics_skew_bit1,
  input wire logic graphics_skew_bit0,
  input wire logic [2:0] graphics_clock_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [21:0] cfg;
  assign cfg = {spread_center, spread_enable, spread_bw_bit1,
    spread_bw_bit0, aux_cpu_clock_en, cpu_clock_en, pci_drive_boost,
    pci_clock_en, selectable_periph_48m, usb_clock_en,
    selectable_periph_en, graphics_skew_bit1, graphics_skew_bit0,
    graphics_clock_en};

  AST_RST_B1: assert property (
    $fell(sys_rst) |-> cfg[21:16] == 6'h1F)
    else $error("byte 1 outputs wrong after reset");
  AST_RST_B2: assert property (
    $fell(sys_rst) |-> cfg[15:8] == 8'h7F)
    else $error("byte 2 outputs wrong after reset");
  AST_RST_B3: assert property (
    $fell(sys_rst) |-> cfg[7:0] == 8'h67)
    else $error("byte 3 outputs wrong after reset");
  AST_CFG_LOW: assert property (
    $changed(cfg) |-> !smb_clk && !$past(smb_clk, 3))
    else $error("control bits changed outside a bus write");
  AST_OE_LOW: assert property (
    $changed(smb_data_oe) |-> !smb_clk)
    else $error("data drive changed while bus clock high");
  AST_PD_IDLE: assert property (
    power_down_n [*6] |-> !cpu_stop_hiz && !cpu_stop_drive)
    else $error("stop state without power-down");
  AST_MODE_IDLE: assert property (
    !cpu_mode_strap [*6] |-> !cpu_stop_hiz && !cpu_stop_drive)
    else $error("stop state in second processor mode");
  AST_PD_ACTIVE: assert property (
    (!power_down_n && cpu_mode_strap) [*6] |->
      cpu_stop_hiz != cpu_stop_drive)
    else $error("no single stop state in power-down");
endmodule // ckg_clock_regs_chk

bind ckg_clock_regs ckg_clock_regs_chk u_chk (.*);
`default_nettype wire

// ### verification/ckg_clock_regs_tb_top.sv
// Testbench for the clock generator control register bank.
// Assumes ckg_smb_host as bus host and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module ckg_clock_regs_tb_top;
  logic mclk, sys_rst, smb_clk, smb_data_in, smb_data_out, smb_data_oe;
  logic [3:0] freq_sel_strap;
  logic memory_mode_strap, cpu_mode_strap, current_multiplier_strap;
  logic power_down_n, sda_low;
  logic freq_sel_bit0, freq_sel_bit1, freq_sel_bit2, freq_sel_bit3;
  logic spread_center, spread_enable, spread_bw_bit1, spread_bw_bit0;
  logic aux_cpu_clock_en, cpu_clock_en, cpu_stop_hiz, cpu_stop_drive;
  logic pci_drive_boost, selectable_periph_48m, usb_clock_en;
  logic selectable_periph_en, graphics_skew_bit1, graphics_skew_bit0;
  logic [6:0] pci_clock_en;
  logic [2:0] graphics_clock_en;
  logic [3:0] fs;
  logic [5:0] b1o;
  logic [7:0] b2o, b3o, q;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  // Open-drain data line with pull-up
  assign smb_data_in = ~sda_low & (smb_data_oe ? smb_data_out : 1'b1);
  assign fs = {freq_sel_bit3, freq_sel_bit2, freq_sel_bit1, freq_sel_bit0};
  assign b1o = {spread_center, spread_enable, spread_bw_bit1,
    spread_bw_bit0, aux_cpu_clock_en, cpu_clock_en};
  assign b2o = {pci_drive_boost, pci_clock_en};
  assign b3o = {selectable_periph_48m, usb_clock_en, selectable_periph_en,
    graphics_skew_bit1, graphics_skew_bit0, graphics_clock_en};

  ckg_clock_regs DUT (.*);
  ckg_smb_host host (.scl(smb_clk), .sda(smb_data_in), .sda_low(sda_low));

  function automatic logic [7:0] b0(input logic [3:0] f, input logic we);
    return {1'b0, f[2:0], we, memory_mode_strap, f[3], cpu_mode_strap};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    host.wq = {d};
    host.xfer({1'b1, o}, 1'b0, 0);
  endtask

  task automatic rd(input logic [6:0] o, input logic [7:0] e);
    host.wq = {};
    host.xfer({1'b1, o}, 1'b1, 1);
    `CHK(host.rq[0], e)
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    sys_rst = 1'b1;
    freq_sel_strap = 4'hA;
    memory_mode_strap = 1'b1;
    cpu_mode_strap = 1'b1;
    current_multiplier_strap = 1'b1;
    power_down_n = 1'b1;
    tick(12);
    sys_rst = 1'b0;
    tick(8);
    rd(0, b0(4'hA, 1'b0));
    rd(1, 8'h7F);
    rd(2, 8'h7F);
    rd(3, 8'h67);
    `CHK(fs, 4'hA)
    $display("reset test done");
    wr(0, 8'h72);
    rd(0, b0(4'hA, 1'b0));
    tick(1);
    freq_sel_strap = 4'h5;
    tick(8);
    rd(0, b0(4'h5, 1'b0));
    `CHK(fs, 4'h5)
    $display("strap test done");
    wr(0, 8'h08);
    wr(0, 8'h5A);
    rd(0, b0(4'hD, 1'b1));
    tick(1);
    freq_sel_strap = 4'h0;
    tick(8);
    `CHK(fs, 4'hD)
    $display("frequency write test done");
    wr(1, 8'h02);
    `CHK(b1o, 6'h00)
    rd(1, 8'h03);
    tick(1);
    power_down_n = 1'b0;
    tick(8);
    `CHK({cpu_stop_hiz, cpu_stop_drive}, 2'b10)
    wr(1, 8'hB5);
    `CHK(b1o, 6'h2D)
    `CHK({cpu_stop_hiz, cpu_stop_drive}, 2'b01)
    tick(1);
    cpu_mode_strap = 1'b0;
    memory_mode_strap = 1'b0;
    current_multiplier_strap = 1'b0;
    tick(8);
    `CHK({cpu_stop_hiz, cpu_stop_drive}, 2'b00)
    rd(0, b0(4'hD, 1'b1));
    rd(1, 8'hB4);
    tick(1);
    cpu_mode_strap = 1'b1;
    memory_mode_strap = 1'b1;
    current_multiplier_strap = 1'b1;
    power_down_n = 1'b1;
    tick(8);
    $display("processor clock test done");
    for (int c = 0; c < 4; c++) begin
      q = {3'b101, c[1:0], 3'b010};
      wr(3, q);
      `CHK(b3o, q)
    end
    rd(3, q);
    $display("skew test done");
    host.wq = {8'h04, 8'h08, 8'hC1, 8'hAA, 8'h12, 8'hEE};
    host.xfer(8'h00, 1'b0, 0);
    `CHK(b2o, 8'hAA)
    host.wq = {};
    host.xfer(8'h00, 1'b1, 5);
    exp_q = {8'h04, b0(4'h0, 1'b1), 8'hC1, 8'hAA, 8'h12};
    foreach (exp_q[i]) `CHK(host.rq[i], exp_q[i])
    $display("block test done");
    wr(7'h05, 8'h00);
    rd(7'h05, 8'h00);
    host.wq = {8'h00};
    host.xfer(8'h40, 1'b0, 0);
    `CHK(b2o, 8'hAA)
    `CHK(host.nak, 0)
    host.adr = 7'h12;
    wr(2, 8'h00);
    host.adr = `CKG_TARGET_ADDR;
    `CHK(host.nak, 3)
    `CHK(b2o, 8'hAA)
    $display("refusal test done");
    wrap_up();
  end
endmodule // ckg_clock_regs_tb_top
`default_nettype wire

// ### verification/ckg_smb_host.sv
// Bus host model for the two-wire management bus.
// Assumes a pull-up on data; the clock idles high between frames.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_regs.svh"

module ckg_smb_host (
  input wire logic sda,
  output var logic scl,
  output var logic sda_low
);
  logic [6:0] adr = `CKG_TARGET_ADDR;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int nak = 0;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bitx(input logic b, output logic r);
    #31.25 sda_low = !b;
    #31.25 scl = 1'b1;
    #31.25 r = sda;
    #31.25 scl = 1'b0;
  endtask

  task automatic start();
    #31.25 sda_low = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b0;
  endtask

  task automatic stop();
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b0;
    #62.5;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] w, input logic last,
    output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(last, a);
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic rd,
    input int nr);
    logic [7:0] r;
    logic a;
    rq = {};
    start();
    byte_io({adr, 1'b0}, 1'b1, r, a);
    nak += a;
    byte_io(cmd, 1'b1, r, a);
    nak += a;
    foreach (wq[i]) begin
      byte_io(wq[i], 1'b1, r, a);
      nak += a;
    end
    if (rd) begin
      start();
      byte_io({adr, 1'b1}, 1'b1, r, a);
      nak += a;
      for (int i = 0; i < nr; i++) begin
        byte_io(8'hFF, i == nr - 1, r, a);
        rq.push_back(r);
      end
    end
    stop();
  endtask
endmodule // ckg_smb_host
`default_nettype wire
